// ### hdl/rirq_pkg.sv
// constants for the reset and interrupt pin control block
package rirq_pkg;
    // control register address and field positions
    localparam logic [7:0] CTRL_ADDR       = 8'h0E;
    localparam int         OSC_DISABLE_BIT = 7;
    localparam int         RATE_HI_BIT     = 4;
    localparam int         RATE_LO_BIT     = 3;
    localparam int         IRQ_MODE_BIT    = 2;
    localparam int         ALARM2_EN_BIT   = 1;
    localparam int         ALARM1_EN_BIT   = 0;
    localparam logic [7:0] CTRL_RESET      = 8'h04; // interrupt mode, alarms off

    // clock rates
    localparam int CORE_HZ = 25_000_000;
    localparam int OSC_HZ  = 32_768;

    // pin timings in their own units
    localparam int DEBOUNCE_MS  = 250;
    localparam int RESET_MS     = 250;
    localparam int RECOVERY_MS  = 250;
    localparam int STOP_QUAL_MS = 100;
    localparam int OSC_ALIVE_US = 100;

    // oscillator ticks for the pin timers, least times rounded up
    localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * OSC_HZ + 999) / 1000;
    localparam int RESET_TICKS    = (RESET_MS * OSC_HZ + 999) / 1000;
    localparam int RECOVERY_TICKS = (RECOVERY_MS * OSC_HZ + 999) / 1000;

    // core clock cycles
    localparam int STOP_QUAL_CYC = STOP_QUAL_MS * (CORE_HZ / 1000);
    localparam int OSC_ALIVE_CYC = OSC_ALIVE_US * (CORE_HZ / 1_000_000);
    localparam int SETTLE_CYC    = 8;

    // widths
    localparam int TMR_W  = 13;
    localparam int IDLE_W = 22;
    localparam int DIV_W  = 15;

    // reset pin sequencer states
    typedef enum logic [2:0] {
        RIRQ_IDLE,
        RIRQ_PWR_FAIL,
        RIRQ_RECOVERY,
        RIRQ_DEBOUNCE,
        RIRQ_CHECK,
        RIRQ_WAIT_RELEASE,
        RIRQ_PULSE
    } rirq_state_e;
endpackage : rirq_pkg

// ### hdl/rirq_sync3.sv
// three-stage input synchroniser with agreed level and edge pulses
module rirq_sync3
    import rirq_pkg::*;
(
    input  wire logic core_clk,   // core clock
    input  wire logic rst,        // async reset, active high
    input  wire logic ce,         // clock enable
    input  wire logic async_in,   // raw pin level
    input  wire logic reset_val,  // unused, level resets to 0
    output logic      level,      // agreed level
    output logic      rise,       // one-cycle pulse on agreed rise
    output logic      fall        // one-cycle pulse on agreed fall
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // agreement of second and third stage
    always_comb
    begin
        next_level = (s2 == s3) ? s2 : level;
    end

    assign rise = ~level & next_level;
    assign fall = level & ~next_level;

    // stages and agreed level
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end
        else if (ce)
        begin
            s1    <= async_in;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end

    // reset_val is a hint for callers only
    logic unused_rv;
    assign unused_rv = reset_val;
endmodule : rirq_sync3

// ### hdl/rirq_top.sv
// reset pin sequencer, interrupt or square-wave pin, clock output and stop flag
module rirq_top
    import rirq_pkg::*;
#(
    parameter int DEBOUNCE_N = DEBOUNCE_TICKS, // oscillator ticks
    parameter int RESET_N    = RESET_TICKS,    // oscillator ticks
    parameter int RECOVERY_N = RECOVERY_TICKS, // oscillator ticks
    parameter int STOP_N     = STOP_QUAL_CYC   // core cycles
)
(
    input  wire logic       core_clk,            // 25 MHz core clock
    input  wire logic       rst,                 // async reset, active high
    input  wire logic       ce,                  // clock enable, freezes state
    input  wire logic [7:0] reg_addr,            // register address
    input  wire logic       reg_wr_en,           // register write strobe
    input  wire logic [7:0] reg_wr_data,         // register write data
    output logic      [7:0] reg_rd_data,         // register read data
    input  wire logic [1:0] alarm_match,         // alarm compare pulses
    input  wire logic [1:0] alarm_flag_clear,    // alarm flag clear pulses
    output logic      [1:0] alarm_flags,         // sticky alarm flags
    input  wire logic       osc_in,              // internal oscillator, async
    input  wire logic       power_fail_in,       // supply below threshold, async
    input  wire logic       fixed_clock_enable,  // clock output enable
    input  wire logic       stop_flag_clear,     // stop flag clear pulse
    output logic            oscillator_stop_flag,// oscillator stopped
    input  wire logic       rst_pin_in,          // reset pin level
    output logic            rst_pin_out,         // reset pin drive value
    output logic            rst_pin_oe_n,        // reset pin enable, low drives
    output logic            irq_wave_out,        // shared pin drive value
    output logic            irq_wave_oe_n,       // shared pin enable, low drives
    output logic            clk32_out,           // clock pin drive value
    output logic            clk32_oe_n           // clock pin enable, low drives
);
    localparam logic [TMR_W-1:0]  DEB_LOAD = TMR_W'(DEBOUNCE_N - 1);
    localparam logic [TMR_W-1:0]  RST_LOAD = TMR_W'(RESET_N - 1);
    localparam logic [TMR_W-1:0]  REC_LOAD = TMR_W'(RECOVERY_N - 1);
    localparam logic [IDLE_W-1:0] STOP_LIM = IDLE_W'(STOP_N);
    localparam logic [IDLE_W-1:0] ALIVE_LIM = IDLE_W'(OSC_ALIVE_CYC);
    localparam logic [3:0]        SETTLE_LIM = 4'(SETTLE_CYC);

    logic [7:0]        ctrl;
    logic [7:0]        next_ctrl;
    logic [7:0]        next_rd;
    logic [1:0]        next_flags;
    logic [DIV_W-1:0]  div;
    logic [DIV_W-1:0]  next_div;
    logic [IDLE_W-1:0] idle_cnt;
    logic [IDLE_W-1:0] next_idle;
    logic              next_stop;
    logic              wave_bit;
    logic              alarm_active;
    logic              next_irq_oe_n;
    logic              next_clk_oe_n;
    logic              osc_level;
    logic              osc_tick;
    logic              pin_level;
    logic              pin_fall;
    logic              pf_level;
    logic              osc_alive;
    logic              rec_enabled;
    logic              drive_zero;
    rirq_state_e       state;
    rirq_state_e       next_state;
    logic [TMR_W-1:0]  tmr;
    logic [TMR_W-1:0]  next_tmr;
    logic [3:0]        settle;
    logic [3:0]        next_settle;
    logic              next_rst_oe_n;

    // square-wave tap for the two rate bits
    function automatic logic rate_tap(input logic [1:0] rs, input logic [DIV_W-1:0] d);
        case (rs)
            2'b00:   rate_tap = d[14]; // 1 Hz
            2'b01:   rate_tap = d[4];  // 1.024 kHz
            2'b10:   rate_tap = d[2];  // 4.096 kHz
            default: rate_tap = d[1];  // 8.192 kHz
        endcase
    endfunction : rate_tap

    // input synchronisers
    rirq_sync3 u_sync_osc (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .async_in  (osc_in),
        .reset_val (1'b0),
        .level     (osc_level),
        .rise      (osc_tick),
        .fall      ()
    );
    rirq_sync3 u_sync_pin (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .async_in  (rst_pin_in),
        .reset_val (1'b0),
        .level     (pin_level),
        .rise      (),
        .fall      (pin_fall)
    );
    rirq_sync3 u_sync_pf (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .async_in  (power_fail_in),
        .reset_val (1'b0),
        .level     (pf_level),
        .rise      (),
        .fall      ()
    );

    // control register, flags, divider, stop detector, shared pins
    always_comb
    begin
        next_ctrl = ctrl;
        if (reg_wr_en && reg_addr == CTRL_ADDR)
            next_ctrl = reg_wr_data;
        next_rd = (reg_addr == CTRL_ADDR) ? ctrl : 8'h00;
        next_div = osc_tick ? div + DIV_W'(1) : div;
        wave_bit = rate_tap({ctrl[RATE_HI_BIT], ctrl[RATE_LO_BIT]}, div);
        alarm_active = (alarm_flags[0] & ctrl[ALARM1_EN_BIT])
                     | (alarm_flags[1] & ctrl[ALARM2_EN_BIT]);
        if (ctrl[IRQ_MODE_BIT])
            next_irq_oe_n = ~alarm_active;
        else
            next_irq_oe_n = wave_bit;
        next_idle = osc_tick ? '0 : ((idle_cnt == STOP_LIM) ? idle_cnt : idle_cnt + IDLE_W'(1));
        next_stop = oscillator_stop_flag;
        if (stop_flag_clear)
            next_stop = 1'b0;
        if (next_idle == STOP_LIM)
            next_stop = 1'b1; // set wins over clear
        next_clk_oe_n = ~(fixed_clock_enable & ~osc_level);
    end

    // alarm flags, set wins over clear
    for (genvar i = 0; i < 2; i++)
    begin : g_flag
        always_comb
        begin
            next_flags[i] = alarm_match[i] | (alarm_flags[i] & ~alarm_flag_clear[i]);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl                 <= CTRL_RESET;
            reg_rd_data          <= 8'h00;
            alarm_flags          <= 2'b00;
            div                  <= '0;
            idle_cnt             <= '0;
            oscillator_stop_flag <= 1'b0;
            irq_wave_oe_n        <= 1'b1;
            clk32_oe_n           <= 1'b1;
            drive_zero           <= 1'b0;
        end
        else if (ce)
        begin
            ctrl                 <= next_ctrl;
            reg_rd_data          <= next_rd;
            alarm_flags          <= next_flags;
            div                  <= next_div;
            idle_cnt             <= next_idle;
            oscillator_stop_flag <= next_stop;
            irq_wave_oe_n        <= next_irq_oe_n;
            clk32_oe_n           <= next_clk_oe_n;
            drive_zero           <= 1'b0;
        end
    end

    // open-drain pins only ever drive low
    assign irq_wave_out = drive_zero;
    assign rst_pin_out  = drive_zero;
    assign clk32_out    = drive_zero;

    // reset pin sequencer
    always_comb
    begin
        osc_alive   = idle_cnt < ALIVE_LIM;
        rec_enabled = ~ctrl[OSC_DISABLE_BIT] & osc_alive;
        next_state  = state;
        next_tmr    = (osc_tick && tmr != '0) ? tmr - TMR_W'(1) : tmr;
        next_settle = settle;
        case (state)
            RIRQ_IDLE:
                if (pin_fall)
                begin
                    next_state = RIRQ_DEBOUNCE;
                    next_tmr   = DEB_LOAD;
                end
            RIRQ_PWR_FAIL:
                if (!pf_level)
                begin
                    if (rec_enabled)
                    begin
                        next_state = RIRQ_RECOVERY;
                        next_tmr   = REC_LOAD;
                    end
                    else
                        next_state = RIRQ_IDLE;
                end
            RIRQ_RECOVERY:
                if (osc_tick && tmr == '0)
                    next_state = RIRQ_IDLE;
            RIRQ_DEBOUNCE:
                if (osc_tick && tmr == '0)
                begin
                    next_state  = RIRQ_CHECK;
                    next_settle = '0;
                end
            RIRQ_CHECK:
                if (settle == SETTLE_LIM)
                    next_state = pin_level ? RIRQ_IDLE : RIRQ_WAIT_RELEASE;
                else
                    next_settle = settle + 4'd1;
            RIRQ_WAIT_RELEASE:
                if (pin_level)
                begin
                    next_state = RIRQ_PULSE;
                    next_tmr   = RST_LOAD;
                end
            RIRQ_PULSE:
                if (osc_tick && tmr == '0)
                    next_state = RIRQ_IDLE;
            default:
                next_state = RIRQ_PWR_FAIL;
        endcase
        if (pf_level)
            next_state = RIRQ_PWR_FAIL;
        next_rst_oe_n = (next_state == RIRQ_IDLE) || (next_state == RIRQ_CHECK)
                     || (next_state == RIRQ_WAIT_RELEASE);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state        <= RIRQ_PWR_FAIL;
            tmr          <= '0;
            settle       <= '0;
            rst_pin_oe_n <= 1'b0;
        end
        else if (ce)
        begin
            state        <= next_state;
            tmr          <= next_tmr;
            settle       <= next_settle;
            rst_pin_oe_n <= next_rst_oe_n;
        end
    end

    // checks
    sequence s_button_edge;
        ce && state == RIRQ_IDLE && pin_fall && !pf_level;
    endsequence

    property p_wave_mode;
        @(posedge core_clk) disable iff (rst)
        ce && !ctrl[IRQ_MODE_BIT] |=> irq_wave_oe_n == $past(wave_bit);
    endproperty
    a_wave_mode: assert property (p_wave_mode) else $error("wave mode pin wrong");

    property p_irq_mode;
        @(posedge core_clk) disable iff (rst)
        ce && ctrl[IRQ_MODE_BIT] && alarm_active |=> !irq_wave_oe_n;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("alarm not on pin");

    property p_reset_mode;
        @(posedge core_clk) $fell(rst) |-> ctrl == CTRL_RESET;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("bad control after reset");

    property p_open_drain;
        @(posedge core_clk) disable iff (rst)
        irq_wave_out == 1'b0 && rst_pin_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin drives high");

    property p_power_fail;
        @(posedge core_clk) disable iff (rst)
        ce && pf_level |=> !rst_pin_oe_n && state == RIRQ_PWR_FAIL;
    endproperty
    a_power_fail: assert property (p_power_fail) else $error("reset not low");

    property p_bypass;
        @(posedge core_clk) disable iff (rst)
        ce && state == RIRQ_PWR_FAIL && !pf_level && ctrl[OSC_DISABLE_BIT] |=> rst_pin_oe_n;
    endproperty
    a_bypass: assert property (p_bypass) else $error("recovery not bypassed");

    property p_recovery;
        @(posedge core_clk) disable iff (rst)
        ce && state == RIRQ_RECOVERY && tmr != '0 && !pin_fall |=> !rst_pin_oe_n [*2];
    endproperty
    a_recovery: assert property (p_recovery) else $error("recovery released early");

    property p_debounce;
        @(posedge core_clk) disable iff (rst)
        s_button_edge |=> state == RIRQ_DEBOUNCE && !rst_pin_oe_n && tmr == DEB_LOAD;
    endproperty
    a_debounce: assert property (p_debounce) else $error("button edge missed");

    property p_stop_flag;
        @(posedge core_clk) disable iff (rst)
        ce && $rose(oscillator_stop_flag) |-> idle_cnt == STOP_LIM;
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("stop flag early");

    property p_ctrl_stable;
        @(posedge core_clk) disable iff (rst)
        ce && !reg_wr_en |=> $stable(ctrl);
    endproperty
    a_ctrl_stable: assert property (p_ctrl_stable) else $error("control changed");

    property p_clk_out;
        @(posedge core_clk) disable iff (rst)
        ce && fixed_clock_enable && !osc_level |=> !clk32_oe_n;
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock output idle");
endmodule : rirq_top

// ### test/rirq_host_model.sv
// host side of the pins: pullups and a pushbutton switch
module rirq_host_model
(
    input  wire logic rst_pin_oe_n,  // device pulls reset pin
    input  wire logic irq_wave_oe_n, // device pulls shared pin
    input  wire logic clk32_oe_n,    // device pulls clock pin
    input  wire logic button,        // switch closed, pin to ground
    output logic      rst_pin_lvl,   // resolved reset pin
    output logic      irq_pin_lvl,   // resolved shared pin
    output logic      clk32_lvl      // resolved clock pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // internal pullup, either the device or the switch pulls low
    assign rst_pin_lvl = rst_pin_oe_n & ~button;
    // external pullups, pins are only ever pulled low
    assign irq_pin_lvl = irq_wave_oe_n;
    assign clk32_lvl   = clk32_oe_n;
endmodule : rirq_host_model

// ### test/testbench.sv
// self-checking bench for the reset and interrupt pin control block
module testbench
    import rirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N     = 4;     // shortened timer counts
    localparam int TK    = 763;   // core cycles per oscillator tick
    localparam int OSC_H = 15259; // oscillator half period, ns
    localparam int OSC_P = 30518; // oscillator period, ns

    logic       core_clk;
    logic       rst                = 1'h1;
    logic       ce                 = 1'h1;
    logic [7:0] reg_addr           = 8'h00;
    logic       reg_wr_en          = 1'h0;
    logic [7:0] reg_wr_data        = 8'h00;
    logic [1:0] alarm_match        = 2'h0;
    logic [1:0] alarm_flag_clear   = 2'h0;
    logic       osc_in             = 1'h0;
    logic       osc_run            = 1'h1;
    logic       power_fail_in      = 1'h0;
    logic       fixed_clock_enable = 1'h0;
    logic       stop_flag_clear    = 1'h0;
    logic       button             = 1'h0;
    logic [7:0] reg_rd_data;
    logic [1:0] alarm_flags;
    logic       oscillator_stop_flag, rst_pin_out, rst_pin_oe_n, irq_wave_out;
    logic       irq_wave_oe_n, clk32_out, clk32_oe_n, rst_pin_lvl, irq_pin_lvl, clk32_lvl;
    int         error_cnt          = 0;
    int         tests_run          = 0;

    // device with shortened timers
    rirq_top #(.DEBOUNCE_N(N), .RESET_N(N), .RECOVERY_N(N), .STOP_N(5000)) u_rirq_top (
        .core_clk, .rst, .ce, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_data,
        .alarm_match, .alarm_flag_clear, .alarm_flags, .osc_in, .power_fail_in,
        .fixed_clock_enable, .stop_flag_clear, .oscillator_stop_flag,
        .rst_pin_in(rst_pin_lvl), .rst_pin_out, .rst_pin_oe_n, .irq_wave_out,
        .irq_wave_oe_n, .clk32_out, .clk32_oe_n
    );
    // pullups and switch on the pins
    rirq_host_model u_rirq_host_model (
        .rst_pin_oe_n, .irq_wave_oe_n, .clk32_oe_n, .button,
        .rst_pin_lvl, .irq_pin_lvl, .clk32_lvl
    );

    // core clock and a stoppable oscillator
    initial
    begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    always #OSC_H osc_in = osc_run ? ~osc_in : osc_in;

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // low time must end within the last of n oscillator ticks
    task automatic span(input string what, input int cyc, input int n);
        check(what, 32'(cyc > (n - 1) * TK && cyc <= n * TK + 12), 32'h1);
    endtask : span

    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr    <= a;
        reg_wr_en   <= 1'h1;
        reg_wr_data <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'h0;
        repeat (3) @(negedge core_clk);
    endtask : wr

    // register read, data one cycle after address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(negedge core_clk);
        d = reg_rd_data;
    endtask : rd

    // alarm match and clear pulses
    task automatic pulse(input logic [1:0] m, input logic [1:0] c);
        @(posedge core_clk);
        alarm_match      <= m;
        alarm_flag_clear <= c;
        @(posedge core_clk);
        alarm_match      <= 2'h0;
        alarm_flag_clear <= 2'h0;
        repeat (3) @(negedge core_clk);
    endtask : pulse

    // bounded wait for the reset pin enable
    task automatic wait_oe(input logic v, input int lim, output int c);
        c = 0;
        while (rst_pin_oe_n !== v && c < lim)
        begin
            @(negedge core_clk);
            c++;
        end
    endtask : wait_oe

    // cycles from a fall to the next rise of a pin, 0 if none
    task automatic half(input bit sel, input int lim, output int cyc);
        int   t0;
        logic p;
        logic s;
        t0  = -1;
        p   = 1'h0;
        cyc = 0;
        for (int i = 0; i < lim && cyc == 0; i++)
        begin
            @(negedge core_clk);
            s = sel ? clk32_lvl : irq_pin_lvl;
            if (p === 1'h1 && s === 1'h0)
                t0 = i;
            if (p === 1'h0 && s === 1'h1 && t0 >= 0)
                cyc = i - t0;
            p = s;
        end
    endtask : half

    // supply dip and return, c is the release delay
    task automatic pf_cycle(output int c);
        @(posedge core_clk);
        power_fail_in <= 1'h1;
        wait_oe(1'h0, 10, c);
        check("pf_low", 32'(rst_pin_oe_n === 1'h0 && c <= 6), 32'h1);
        @(posedge core_clk);
        power_fail_in <= 1'h0;
        wait_oe(1'h1, 5 * TK, c);
    endtask : pf_cycle

    // state after reset and power-up recovery
    task automatic t_reset();
        logic [7:0] d;
        int         c;
        check("pin_rst_low", rst_pin_oe_n, 1'h0);
        check("irq_idle", irq_wave_oe_n, 1'h1);
        check("drive_vals", {rst_pin_out, irq_wave_out, clk32_out}, 3'h0);
        rd(CTRL_ADDR, d);
        check("ctrl_reset", d, CTRL_RESET);
        wait_oe(1'h1, 5 * TK, c);
        check("recov_end", rst_pin_oe_n, 1'h1);
    endtask : t_reset

    // control register and an unmapped address
    task automatic t_regs();
        logic [7:0] d;
        wr(CTRL_ADDR, 8'h7B);
        wr(8'h0D, 8'hFF);
        // a write while the clock enable is low must not land
        @(posedge core_clk);
        ce <= 1'h0;
        wr(CTRL_ADDR, 8'h00);
        @(posedge core_clk);
        ce <= 1'h1;
        rd(CTRL_ADDR, d);
        check("ctrl_rw", d, 8'h7B);
        rd(8'h0D, d);
        check("unmapped", d, 8'h00);
        wr(CTRL_ADDR, CTRL_RESET);
    endtask : t_regs

    // interrupt mode with each alarm enabled and alarm 1 disabled
    task automatic t_alarm();
        wr(CTRL_ADDR, 8'h06);
        pulse(2'h1, 2'h0);
        check("flag1", alarm_flags, 2'h1);
        check("irq_dis", irq_pin_lvl, 1'h1);
        pulse(2'h2, 2'h0);
        check("irq_a2", irq_pin_lvl, 1'h0);
        pulse(2'h1, 2'h3);
        check("set_wins", alarm_flags, 2'h1);
        wr(CTRL_ADDR, 8'h05);
        check("irq_a1", irq_pin_lvl, 1'h0);
        pulse(2'h0, 2'h1);
        check("irq_clr", irq_pin_lvl, 1'h1);
    endtask : t_alarm

    // square-wave half periods in half oscillator ticks
    task automatic t_wave();
        int dv [1:3] = '{32, 8, 4};
        int c;
        for (int r = 3; r > 0; r--)
        begin
            wr(CTRL_ADDR, 8'(r * 8));
            half(1'b0, 40000, c);
            check("wave_half", (c * 80 + OSC_H) / OSC_P, dv[r]);
        end
        wr(CTRL_ADDR, CTRL_RESET);
    endtask : t_wave

    // power fail, clock output on backup, recovery delay
    task automatic t_power();
        logic [7:0] d;
        int         c;
        @(posedge core_clk);
        power_fail_in      <= 1'h1;
        fixed_clock_enable <= 1'h1;
        wait_oe(1'h0, 10, c);
        check("pf_low", 32'(rst_pin_oe_n === 1'h0 && c <= 6), 32'h1);
        half(1'b1, 2000, c);
        check("clk32_half", (c * 80 + OSC_H) / OSC_P, 32'h1);
        @(posedge core_clk);
        fixed_clock_enable <= 1'h0;
        half(1'b1, 2000, c);
        check("clk32_off", c, 32'h0);
        wr(CTRL_ADDR, 8'h64);
        rd(CTRL_ADDR, d);
        check("ctrl_in_pf", d, 8'h64);
        wr(CTRL_ADDR, CTRL_RESET);
        @(posedge core_clk);
        power_fail_in <= 1'h0;
        wait_oe(1'h1, 5 * TK, c);
        span("recovery", c, N);
    endtask : t_power

    // oscillator disabled or stopped skips recovery; stop flag
    task automatic t_osc();
        int c;
        wr(CTRL_ADDR, 8'h84);
        pf_cycle(c);
        check("bypass_dis", 32'(c <= 8), 32'h1);
        wr(CTRL_ADDR, CTRL_RESET);
        osc_run = 1'h0;
        repeat (4200) @(negedge core_clk);
        check("stop_early", oscillator_stop_flag, 1'h0);
        repeat (820) @(negedge core_clk);
        check("stop_set", oscillator_stop_flag, 1'h1);
        pf_cycle(c);
        check("bypass_stop", 32'(c <= 8), 32'h1);
        osc_run = 1'h1;
        repeat (1600) @(posedge core_clk);
        stop_flag_clear <= 1'h1;
        @(posedge core_clk);
        stop_flag_clear <= 1'h0;
        repeat (3) @(negedge core_clk);
        check("stop_clr", oscillator_stop_flag, 1'h0);
    endtask : t_osc

    // short press gives no pulse, long press pulses after release
    task automatic t_button();
        int c;
        int bad;
        bad = 0;
        @(posedge core_clk);
        button <= 1'h1;
        wait_oe(1'h0, 10, c);
        check("btn_detect", 32'(rst_pin_oe_n === 1'h0 && c <= 6), 32'h1);
        repeat (100) @(posedge core_clk);
        button <= 1'h0;
        wait_oe(1'h1, 5 * TK, c);
        span("debounce", c + 100, N);
        repeat (2 * TK) @(negedge core_clk) bad += int'(rst_pin_oe_n !== 1'h1);
        check("no_pulse", bad, 32'h0);
        @(posedge core_clk);
        button <= 1'h1;
        wait_oe(1'h0, 10, c);
        repeat (6 * TK) @(negedge core_clk);
        check("held_wait", rst_pin_oe_n, 1'h1);
        @(posedge core_clk);
        button <= 1'h0;
        wait_oe(1'h0, 10, c);
        check("pulse_go", 32'(rst_pin_oe_n === 1'h0 && c <= 6), 32'h1);
        wait_oe(1'h1, 5 * TK, c);
        span("pulse", c, N);
    endtask : t_button

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        #1;
        t_reset();
        t_regs();
        t_alarm();
        t_wave();
        t_power();
        t_osc();
        t_button();
        conclude();
    end

    // watchdog
    initial
    begin
        #(95000 * 40);
        error_cnt++;
        conclude();
    end
endmodule : testbench
